// >>> logic/ct_pkg.sv
// Constants shared by the cascaded 16-bit timer
package ct_pkg;
    // Upper control field positions
    localparam int UPPER_INIT_BIT = 7;
    localparam int UPPER_RUN_BIT = 3;
    localparam int UPPER_MODE_LSB = 0;
    // Lower control field positions
    localparam int LOWER_SRC_LSB = 4;
    localparam int LOWER_CASC_LSB = 0;
    // Lower control cascade code for 16-bit operation
    localparam logic [2:0] LOWER_CASC_16 = 3'h3;
    // Values after reset, and the counter top
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    // Source clock codes in the lower control register
    localparam logic [2:0] SRC_SLOWEST = 3'h0;
    localparam logic [2:0] SRC_DIV7 = 3'h1;
    localparam logic [2:0] SRC_DIV5 = 3'h2;
    localparam logic [2:0] SRC_DIV3 = 3'h3;
    localparam logic [2:0] SRC_FS = 3'h4;
    localparam logic [2:0] SRC_DIV1 = 3'h5;
    localparam logic [2:0] SRC_FC = 3'h6;
    localparam logic [2:0] SRC_EXT = 3'h7;
    // Prescaler tap indices
    localparam int TAP_DIV11 = 0;
    localparam int TAP_DIV7 = 1;
    localparam int TAP_DIV5 = 2;
    localparam int TAP_DIV3 = 3;
    localparam int TAP_FS = 4;
    localparam int TAP_DIV1 = 5;
    localparam int TAP_FS8 = 6;
    localparam int TAP_COUNT = 7;
    // Low-frequency clock period and its length in fast clocks
    localparam int CLK_PERIOD_PS = 10000;
    localparam int FS_PERIOD_PS = 30517578;
    localparam int FS_CYCLES = FS_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [11:0] FS_LAST = 12'(FS_CYCLES - 1);
    // Upper control mode codes
    typedef enum logic [2:0] {
        CT_MODE_OFF = 3'b000,
        CT_MODE_TIMER = 3'b100,
        CT_MODE_PWM = 3'b110,
        CT_MODE_PPG = 3'b111
    } ct_mode_t;
endpackage

// >>> logic/ct_prescaler.sv
`timescale 1ns/100ps
// Free running divider that hands out one-cycle tick enables
module ct_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick enables, one bit per tap
    output logic [ct_pkg::TAP_COUNT-1:0] tick
);
    // All divider state
    typedef struct packed {
        logic [10:0] fc_div;
        logic [11:0] fs_div;
        logic [2:0] fs8_div;
        logic [ct_pkg::TAP_COUNT-1:0] tick;
    } ct_pre_t;

    ct_pre_t st_r;
    ct_pre_t st_nxt;

    // Next state of the dividers and ticks
    always_comb begin
        st_nxt = st_r;
        st_nxt.fc_div = st_r.fc_div + 11'h001;
        st_nxt.tick = '0;
        st_nxt.tick[ct_pkg::TAP_DIV11] = &st_r.fc_div[10:0];
        st_nxt.tick[ct_pkg::TAP_DIV7] = &st_r.fc_div[6:0];
        st_nxt.tick[ct_pkg::TAP_DIV5] = &st_r.fc_div[4:0];
        st_nxt.tick[ct_pkg::TAP_DIV3] = &st_r.fc_div[2:0];
        st_nxt.tick[ct_pkg::TAP_DIV1] = st_r.fc_div[0];
        // Low-frequency tick from its own count
        if (st_r.fs_div == ct_pkg::FS_LAST) begin
            st_nxt.fs_div = 12'h000;
            st_nxt.tick[ct_pkg::TAP_FS] = 1'b1;
            st_nxt.fs8_div = st_r.fs8_div + 3'h1;
            st_nxt.tick[ct_pkg::TAP_FS8] = &st_r.fs8_div;
        end else begin
            st_nxt.fs_div = st_r.fs_div + 12'h001;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule // ct_prescaler

// >>> logic/ct_timer16.sv
`timescale 1ns/100ps
// Operation
// [R1] Event mode: 16-bit count of falling edges
// [R2] Period match raises irq, clears, keeps counting
// [R3] Source holds each level two machine cycles
// [R4] Software writes match low byte, then high
// [R5] Event period match unbuffered; not changed running
// [R6] Software keeps init bits zero in event mode
// [R7] PWM toggles at duty match and overflow
// [R8] PWM pin drives inverse of output flop
// [R9] Flop starts from init bit; reset clears
// [R10] PWM duty staged, loaded at cascade irq
// [R11] Running PWM duty reads return staged value; code returns the compare stage (duty_cmp)
// [R12] Software writes duty right after the irq
// [R13] Stopped output holds; init changed after stop
// [R14] Upper control: bit 3 run, bit 7 init
// [R15] Software stops counter before stop mode
// [R16] Software sets port latch for output pins
// [R17] Pulse mode toggles at duty and period
// [R18] Pulse pin drives inverse of output flop
// [R19] Pulse duty and period unbuffered, immediate
// [R20] Mode codes 056H, 057H, 05EH, 05FH, 33H
// [R21] Lower byte carries into upper byte
// [R22] Source mux taps, slow modes fs only
module ct_timer16 (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // System operating state
    input wire logic slow_mode,
    input wire logic prescaler_tap_select,
    // External count input pin
    input wire logic ext_count_input,
    // Register writes
    input wire logic [7:0] wr_data,
    input wire logic wr_lower_ctrl,
    input wire logic wr_upper_ctrl,
    input wire logic wr_period_low,
    input wire logic wr_period_high,
    input wire logic wr_duty_low,
    input wire logic wr_duty_high,
    // Register reads
    output logic [7:0] duty_low_rdata,
    output logic [7:0] duty_high_rdata,
    output logic [15:0] count_value,
    // Event and pins
    output logic cascade_match_irq,
    output logic pwm_out_pin,
    output logic pulse_gen_out_pin
);
    // All timer state
    typedef struct packed {
        logic [7:0] lower_ctrl_reg;
        logic [7:0] upper_ctrl_reg;
        logic [15:0] period_match;
        logic [15:0] duty_stage;
        logic [15:0] duty_cmp;
        logic [15:0] cnt;
        logic output_toggle_ff;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic irq;
        logic pwm_pin;
        logic ppg_pin;
        logic [7:0] rd_low;
        logic [7:0] rd_high;
    } ct_state_t;

    ct_state_t st_r;
    ct_state_t st_nxt;
    logic [1:0] rst_sync_r; // Reset release synchroniser
    logic rst_n; // Synchronised reset
    logic [ct_pkg::TAP_COUNT-1:0] tap; // Prescaler ticks
    logic ext_fall; // Falling edge on count input
    logic tick; // Selected count enable
    logic run; // Run bit
    logic casc_ok; // Lower counter set for 16 bits
    logic irq_ev; // Cascade event this cycle
    logic tgl; // Output flop toggle this cycle
    logic [15:0] cnt_inc; // Counter plus one
    ct_pkg::ct_mode_t mode; // Current mode
    logic [2:0] src; // Current source code

    // Reset is released through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Tick generator
    ct_prescaler u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tap)
    );

    // Decoded fields
    // [R14] control bit fields
    assign run = st_r.upper_ctrl_reg[ct_pkg::UPPER_RUN_BIT];
    // [R20] mode codes decoded
    assign mode = ct_pkg::ct_mode_t'(st_r.upper_ctrl_reg[ct_pkg::UPPER_MODE_LSB +: 3]);
    assign src = st_r.lower_ctrl_reg[ct_pkg::LOWER_SRC_LSB +: 3];
    assign casc_ok = st_r.lower_ctrl_reg[ct_pkg::LOWER_CASC_LSB +: 3] == ct_pkg::LOWER_CASC_16;
    // [R1] edge from the third synchroniser stage
    assign ext_fall = st_r.ext_s3 & ~st_r.ext_s2;
    // [R21] one 16-bit carry chain
    assign cnt_inc = st_r.cnt + 16'h0001;

    // Source clock selection
    // [R22] taps and slow-mode limits
    always_comb begin
        tick = 1'b0;
        if (src == ct_pkg::SRC_SLOWEST) begin
            tick = (slow_mode || prescaler_tap_select) ? tap[ct_pkg::TAP_FS8] : tap[ct_pkg::TAP_DIV11];
        end else if (src == ct_pkg::SRC_FS) begin
            tick = tap[ct_pkg::TAP_FS];
        end else if (src == ct_pkg::SRC_EXT) begin
            tick = ext_fall;
        end else if (!slow_mode) begin
            case (src)
                ct_pkg::SRC_DIV7: tick = tap[ct_pkg::TAP_DIV7];
                ct_pkg::SRC_DIV5: tick = tap[ct_pkg::TAP_DIV5];
                ct_pkg::SRC_DIV3: tick = tap[ct_pkg::TAP_DIV3];
                ct_pkg::SRC_DIV1: tick = tap[ct_pkg::TAP_DIV1];
                default: tick = 1'b1;
            endcase
        end
    end

    // Next state of the whole timer
    always_comb begin
        st_nxt = st_r;
        irq_ev = 1'b0;
        tgl = 1'b0;
        // Input synchroniser
        st_nxt.ext_s1 = ext_count_input;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        // Counting, only while running in 16-bit form
        if (run && casc_ok && tick) begin
            case (mode)
                ct_pkg::CT_MODE_TIMER: begin
                    // [R2] period match clears and signals
                    if (cnt_inc == st_r.period_match) begin
                        st_nxt.cnt = ct_pkg::WORD_RST;
                        irq_ev = 1'b1;
                    end else begin
                        // [R1] advance on each event
                        st_nxt.cnt = cnt_inc;
                    end
                end
                ct_pkg::CT_MODE_PWM: begin
                    // [R7] overflow toggles, clears, signals
                    if (st_r.cnt == ct_pkg::CNT_TOP) begin
                        st_nxt.cnt = ct_pkg::WORD_RST;
                        tgl = 1'b1;
                        irq_ev = 1'b1;
                    end else begin
                        st_nxt.cnt = cnt_inc;
                        tgl = cnt_inc == st_r.duty_cmp;
                    end
                end
                ct_pkg::CT_MODE_PPG: begin
                    // [R17] duty toggles, period toggles and clears
                    tgl = cnt_inc == st_r.duty_cmp;
                    if (cnt_inc == st_r.period_match) begin
                        st_nxt.cnt = ct_pkg::WORD_RST;
                        tgl = ~tgl;
                        irq_ev = 1'b1;
                    end else begin
                        st_nxt.cnt = cnt_inc;
                    end
                end
                default: begin
                    st_nxt.cnt = st_r.cnt;
                end
            endcase
        end
        st_nxt.output_toggle_ff = st_r.output_toggle_ff ^ tgl;
        // Control writes
        if (wr_lower_ctrl) begin
            st_nxt.lower_ctrl_reg = wr_data;
        end
        if (wr_upper_ctrl) begin
            st_nxt.upper_ctrl_reg = wr_data;
            // [R13] init level only taken while already stopped
            if (!run) begin
                // [R9] starting level from init bit
                st_nxt.output_toggle_ff = wr_data[ct_pkg::UPPER_INIT_BIT];
                if (wr_data[ct_pkg::UPPER_RUN_BIT]) begin
                    st_nxt.cnt = ct_pkg::WORD_RST;
                end
            end
        end
        // [R5] period match takes effect at once
        if (wr_period_low) begin
            st_nxt.period_match[7:0] = wr_data;
        end
        if (wr_period_high) begin
            st_nxt.period_match[15:8] = wr_data;
        end
        // Duty writes land in the staging register
        if (wr_duty_low) begin
            st_nxt.duty_stage[7:0] = wr_data;
        end
        if (wr_duty_high) begin
            st_nxt.duty_stage[15:8] = wr_data;
        end
        // [R10] staged duty loads at cascade event
        if (run && mode == ct_pkg::CT_MODE_PWM) begin
            if (irq_ev) begin
                st_nxt.duty_cmp = st_nxt.duty_stage;
            end
        end else begin
            // [R19] immediate when stopped or not PWM
            st_nxt.duty_cmp = st_nxt.duty_stage;
        end
        // [R11] running PWM reads show the compare stage
        if (st_nxt.upper_ctrl_reg[ct_pkg::UPPER_RUN_BIT] &&
            st_nxt.upper_ctrl_reg[2:0] == ct_pkg::CT_MODE_PWM) begin
            st_nxt.rd_low = st_nxt.duty_cmp[7:0];
            st_nxt.rd_high = st_nxt.duty_cmp[15:8];
        end else begin
            st_nxt.rd_low = st_nxt.duty_stage[7:0];
            st_nxt.rd_high = st_nxt.duty_stage[15:8];
        end
        st_nxt.irq = irq_ev;
        // [R8] PWM pin inverse of flop, idle high
        st_nxt.pwm_pin = (st_nxt.upper_ctrl_reg[2:0] == ct_pkg::CT_MODE_PWM) ? ~st_nxt.output_toggle_ff : 1'b1;
        // [R18] pulse pin inverse of flop, idle high
        st_nxt.ppg_pin = (st_nxt.upper_ctrl_reg[2:0] == ct_pkg::CT_MODE_PPG) ? ~st_nxt.output_toggle_ff : 1'b1;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{lower_ctrl_reg: ct_pkg::CTRL_RST, upper_ctrl_reg: ct_pkg::CTRL_RST,
                      period_match: ct_pkg::WORD_RST, duty_stage: ct_pkg::WORD_RST,
                      duty_cmp: ct_pkg::WORD_RST, cnt: ct_pkg::WORD_RST, output_toggle_ff: 1'b0,
                      ext_s1: 1'b1, ext_s2: 1'b1, ext_s3: 1'b1, irq: 1'b0, pwm_pin: 1'b1,
                      ppg_pin: 1'b1, rd_low: 8'h00, rd_high: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign duty_low_rdata = st_r.rd_low;
    assign duty_high_rdata = st_r.rd_high;
    assign count_value = st_r.cnt;
    assign cascade_match_irq = st_r.irq;
    assign pwm_out_pin = st_r.pwm_pin;
    assign pulse_gen_out_pin = st_r.ppg_pin;

    // Checks on the timer behaviour
    a_event_advance: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        (run && casc_ok && mode == ct_pkg::CT_MODE_TIMER && src == ct_pkg::SRC_EXT && ext_fall
         && cnt_inc != st_r.period_match && !wr_upper_ctrl) |=> count_value == $past(cnt_inc))
        else $error("event count did not advance");
    a_period_match_irq: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        (run && casc_ok && tick && mode == ct_pkg::CT_MODE_TIMER && cnt_inc == st_r.period_match
         && !wr_upper_ctrl) |=> cascade_match_irq && count_value == 16'h0000)
        else $error("period match did not clear and signal");
    a_pwm_overflow: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        (run && casc_ok && tick && mode == ct_pkg::CT_MODE_PWM && st_r.cnt == 16'hffff && !wr_upper_ctrl)
        |=> cascade_match_irq && st_r.output_toggle_ff != $past(st_r.output_toggle_ff))
        else $error("overflow did not toggle and signal");
    a_pwm_pin_inverse: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        (mode == ct_pkg::CT_MODE_PWM) |-> pwm_out_pin == !st_r.output_toggle_ff)
        else $error("pwm pin not inverse of flop");
    a_ppg_pin_inverse: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        (mode == ct_pkg::CT_MODE_PPG) |-> pulse_gen_out_pin == !st_r.output_toggle_ff)
        else $error("pulse pin not inverse of flop");
    a_init_level_load: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        (wr_upper_ctrl && !run) |=> st_r.output_toggle_ff == $past(wr_data[7]))
        else $error("flop did not take init level");
    a_stopped_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        (!run && !wr_upper_ctrl) |=> $stable(st_r.output_toggle_ff) && $stable(pwm_out_pin))
        else $error("stopped output changed");
    a_duty_stage_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        (run && mode == ct_pkg::CT_MODE_PWM && !irq_ev && !wr_upper_ctrl) |=> $stable(st_r.duty_cmp))
        else $error("active duty changed between events");
    a_duty_read_stage: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        (run && mode == ct_pkg::CT_MODE_PWM) |-> {duty_high_rdata, duty_low_rdata} == st_r.duty_cmp)
        else $error("duty read not from compare stage");
    a_ppg_period_match: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        (run && casc_ok && tick && mode == ct_pkg::CT_MODE_PPG && cnt_inc == st_r.period_match
         && cnt_inc != st_r.duty_cmp && !wr_upper_ctrl)
        |=> cascade_match_irq && count_value == 16'h0000 && $changed(st_r.output_toggle_ff))
        else $error("pulse period match misbehaved");
    a_ppg_immediate: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
        (mode == ct_pkg::CT_MODE_PPG && wr_duty_low && !wr_upper_ctrl) |=> st_r.duty_cmp[7:0] == $past(wr_data))
        else $error("pulse duty not immediate");
endmodule // ct_timer16

// >>> sim/ct_pulse_src.sv
`timescale 1ns/100ps
// Stand-in for the pulse source wired to the count pin
module ct_pulse_src #(
    // Clocks per level, longer than two machine cycles
    parameter int HOLD = 10
) (
    // Clock
    input wire logic clk,
    // Count pin, idles high
    output logic pin
);
    // Pin starts at its idle level
    initial begin
        pin = 1'b1;
    end
    // Sends n falling edges, each level held HOLD clocks
    // minimum level width
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (HOLD) @(posedge clk);
            #1 pin = 1'b0;
            repeat (HOLD) @(posedge clk);
            #1 pin = 1'b1;
        end
    endtask
endmodule // ct_pulse_src

// >>> sim/test_cascaded_16bit_timer_modes.sv
`timescale 1ns/100ps
// Self-checking bench for the cascaded timer
module test_cascaded_16bit_timer_modes;
    // Clock, reset and stimulus
    logic clk;
    logic nrst;
    logic [7:0] wr_data;
    logic [5:0] strb; // lower, upper, period lo/hi, duty lo/hi
    logic ext_pin;
    logic slow_mode; // Slow operation select
    logic tap_sel; // Prescaler tap select
    // Write strobes split out of strb
    logic wr_lc;
    logic wr_uc;
    logic wr_pl;
    logic wr_ph;
    logic wr_dl;
    logic wr_dh;
    // Observed outputs
    logic [7:0] duty_low_rdata;
    logic [7:0] duty_high_rdata;
    logic [15:0] count_value;
    logic irq;
    logic pwm_pin;
    logic ppg_pin;
    // Bookkeeping
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int irq_n = 0;
    int base;
    logic [15:0] held;
    localparam int LIMIT = 90000;

    assign {wr_dh, wr_dl, wr_ph, wr_pl, wr_uc, wr_lc} = strb;

    ct_timer16 i_dut (.clk(clk), .nrst(nrst), .slow_mode(slow_mode), .prescaler_tap_select(tap_sel),
        .ext_count_input(ext_pin), .wr_data(wr_data), .wr_lower_ctrl(wr_lc), .wr_upper_ctrl(wr_uc),
        .wr_period_low(wr_pl), .wr_period_high(wr_ph), .wr_duty_low(wr_dl), .wr_duty_high(wr_dh),
        .duty_low_rdata(duty_low_rdata), .duty_high_rdata(duty_high_rdata), .count_value(count_value),
        .cascade_match_irq(irq), .pwm_out_pin(pwm_pin), .pulse_gen_out_pin(ppg_pin));
    ct_pulse_src i_src (.clk(clk), .pin(ext_pin));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Counts irq pulses and cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1) begin
            irq_n++;
        end
        if (cyc == LIMIT) begin
            err_total++;
            wrap_up();
        end
    end
    // Waits n edges, then lets updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle write strobe on register idx
    task automatic wr(input int idx, input logic [7:0] d);
        tick(1);
        strb = 6'h01 << idx;
        wr_data = d;
        tick(1);
        strb = 6'h00;
    endtask
    // Word write, low byte first
    task automatic wr16(input int idx, input logic [15:0] w);
        wr(idx, w[7:0]);
        wr(idx + 1, w[15:8]);
    endtask
    // Compare and report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for a count value
    task automatic wait_count(input logic [15:0] v, input int lim);
        for (int i = 0; i < lim; i++) begin
            tick(1);
            if (count_value === v) break;
        end
        chk("count reached", v, count_value);
    endtask
    // Bounded wait for the next irq pulse
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim; i++) begin
            tick(1);
            if (irq_n != base) break;
        end
        chk("irq pulses", 16'h0001, 16'(irq_n - base));
    endtask
    // Values right after reset
    task automatic test_reset();
        chk("pwm pin", 16'h0001, {15'h0000, pwm_pin});
        chk("pulse pin", 16'h0001, {15'h0000, ppg_pin});
        chk("count", 16'h0000, count_value);
        chk("duty read", 16'h0000, {duty_high_rdata, duty_low_rdata});
        chk("irq pulses", 16'h0000, 16'(irq_n));
    endtask
    // Event counting, period match and immediate period update
    task automatic test_event();
        wr(0, 8'h73);
        wr16(2, 16'h0003);
        wr(1, 8'h04);
        wr(1, 8'h0c);
        i_src.send(2);
        tick(6);
        chk("event count", 16'h0002, count_value);
        base = irq_n;
        i_src.send(1);
        tick(6);
        chk("irq pulses", 16'h0001, 16'(irq_n - base));
        chk("cleared count", 16'h0000, count_value);
        i_src.send(1);
        tick(6);
        chk("resumed count", 16'h0001, count_value);
        wr16(2, 16'h0002);
        base = irq_n;
        i_src.send(1);
        tick(6);
        chk("new period irq", 16'h0001, 16'(irq_n - base));
        wr(1, 8'h04);
    endtask
    // Source taps gated by slow mode and by the tap select
    task automatic test_src();
        wr(0, 8'h33);
        wr16(2, 16'hffff);
        slow_mode = 1'b1;
        wr(1, 8'h0c);
        tick(40);
        chk("slow mode count", 16'h0000, count_value);
        slow_mode = 1'b0;
        wait_count(16'h0004, 40);
        wr(1, 8'h04);
        wr(0, 8'h03);
        // Low-frequency tap cannot fire this early in the run
        tap_sel = 1'b1;
        wr(1, 8'h0c);
        tick(2100);
        chk("tap select count", 16'h0000, count_value);
        tap_sel = 1'b0;
        wait_count(16'h0001, 2100);
        wr(1, 8'h04);
    endtask
    // Buffered duty, toggles, stop hold and init level
    task automatic test_pwm();
        wr(0, 8'h63);
        wr16(4, 16'h0010);
        tick(1);
        chk("stopped duty read", 16'h0010, {duty_high_rdata, duty_low_rdata});
        wr(1, 8'h56);
        tick(2);
        chk("pwm pin init 0", 16'h0001, {15'h0000, pwm_pin});
        wr(1, 8'h5e);
        wait_count(16'h0020, 100);
        chk("pwm pin after duty", 16'h0000, {15'h0000, pwm_pin});
        wr16(4, 16'h0040);
        tick(1);
        chk("running duty read", 16'h0010, {duty_high_rdata, duty_low_rdata});
        base = irq_n;
        wait_irq(70000);
        tick(2);
        chk("pwm pin after overflow", 16'h0001, {15'h0000, pwm_pin});
        chk("loaded duty read", 16'h0040, {duty_high_rdata, duty_low_rdata});
        wait_count(16'h0050, 200);
        chk("pwm pin new duty", 16'h0000, {15'h0000, pwm_pin});
        wr(1, 8'h56);
        tick(2);
        held = count_value;
        tick(20);
        chk("stopped pin", 16'h0000, {15'h0000, pwm_pin});
        chk("stopped count", held, count_value);
        wr(1, 8'h56);
        tick(2);
        chk("init clear pin", 16'h0001, {15'h0000, pwm_pin});
        wr(1, 8'hd6);
        tick(2);
        chk("init set pin", 16'h0000, {15'h0000, pwm_pin});
        wr(1, 8'h56);
    endtask
    // Pulse mode with a period crossing the byte boundary
    task automatic test_ppg();
        wr(0, 8'h63);
        wr16(4, 16'h0080);
        wr16(2, 16'h0102);
        wr(1, 8'h57);
        tick(2);
        chk("pulse pin init", 16'h0001, {15'h0000, ppg_pin});
        chk("pwm pin idle", 16'h0001, {15'h0000, pwm_pin});
        wr(1, 8'h5f);
        wait_count(16'h00c0, 300);
        chk("pulse pin after duty", 16'h0000, {15'h0000, ppg_pin});
        base = irq_n;
        wait_count(16'h0101, 300);
        wait_irq(10);
        tick(2);
        chk("pulse pin at period", 16'h0001, {15'h0000, ppg_pin});
        chk("count high byte", 16'h0000, 16'(count_value[15:8]));
        wr(1, 8'h57);
    endtask
    // Prints counts and verdict, ends the run
    task automatic wrap_up();
        $display("Mismatches %0d of %0d comparisons", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        nrst = 1'b0;
        wr_data = 8'h00;
        strb = 6'h00;
        slow_mode = 1'b0;
        tap_sel = 1'b0;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        tick(5);
        test_reset();
        test_event();
        test_src();
        test_pwm();
        test_ppg();
        wrap_up();
    end
endmodule // test_cascaded_16bit_timer_modes
